// ==== mdfm_pkg.sv ====
package mdfm_pkg;
    // Register offsets.
    localparam logic [3:0] MDFM_REG_CTRL = 4'h0;
    localparam logic [3:0] MDFM_REG_MODE = 4'h1;
    localparam logic [3:0] MDFM_REG_OC_TIME = 4'h2;
    localparam logic [3:0] MDFM_REG_HL_TIME = 4'h3;
    localparam logic [3:0] MDFM_REG_RETRY = 4'h4;
    localparam logic [3:0] MDFM_REG_STATUS = 4'h5;
    localparam logic [3:0] MDFM_REG_FET_FLAGS = 4'h6;
    localparam logic [3:0] MDFM_REG_CMD = 4'h7;
    // Control register field positions.
    localparam int MDFM_CTRL_OV_EN = 0;
    localparam int MDFM_CTRL_OV_SEL = 1;
    localparam int MDFM_CTRL_ALARM_MASK = 2;
    localparam int MDFM_CTRL_HEAT_REP = 3;
    // Mode register field positions.
    localparam int MDFM_MODE_OC_LSB = 0;
    localparam int MDFM_MODE_HL_LSB = 4;
    // Status register field positions.
    localparam int MDFM_ST_DRIVE_ERR = 0;
    localparam int MDFM_ST_OV = 1;
    localparam int MDFM_ST_OC = 2;
    localparam int MDFM_ST_CTRL_ERR = 3;
    localparam int MDFM_ST_HL = 4;
    localparam int MDFM_ST_OVERTEMP = 5;
    localparam int MDFM_ST_HEAT = 6;
    // Reset values.
    localparam logic [31:0] MDFM_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] MDFM_MODE_RST = 32'h0000_0000;
    localparam logic [15:0] MDFM_OC_TIME_RST = 16'h0004;
    localparam logic [15:0] MDFM_HL_TIME_RST = 16'h0004;
    localparam logic [31:0] MDFM_RETRY_RST = 32'h0000_1000;
    // Overcurrent response modes.
    typedef enum logic [1:0] {
        MDFM_OC_LATCH = 2'b00,
        MDFM_OC_RETRY = 2'b01,
        MDFM_OC_REPORT = 2'b10,
        MDFM_OC_OFF = 2'b11
    } mdfm_oc_mode_t;
    // Bridge output states.
    typedef enum logic [1:0] {
        MDFM_BR_OFF = 2'b00,
        MDFM_BR_RECIRC = 2'b01,
        MDFM_BR_HIGH_ON = 2'b10,
        MDFM_BR_LOW_ON = 2'b11
    } mdfm_bridge_t;
    // Protection handler states.
    typedef enum logic [1:0] {
        MDFM_ST_IDLE = 2'b00,
        MDFM_ST_LATCHED = 2'b01,
        MDFM_ST_RETRYING = 2'b10,
        MDFM_ST_REPORTING = 2'b11
    } mdfm_state_t;
    // Raw detector inputs travel together.
    typedef struct packed {
        logic ov_low_trip;
        logic ov_high_trip;
        logic [5:0] fet_over;
        logic buck_over;
        logic sense_over;
        logic heat_over;
        logic heat_below_hys;
    } mdfm_detect_t;
    // Bridge command to the gate drivers.
    typedef struct packed {
        logic forced;
        mdfm_bridge_t state;
    } mdfm_bridge_cmd_t;
endpackage : mdfm_pkg

// ==== mdfm_filter.sv ====
`timescale 1ns/1ps
// Recognises a level that stays high for longer than a programmed count.
module mdfm_filter #(
    parameter int WIDTH = 16
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Level and its filter length.
    input wire logic level,
    input wire logic [WIDTH-1:0] limit,
    // Filtered result.
    output logic qualified
);
    logic [WIDTH-1:0] count_r;

    // Counting saturates, so a long fault never wraps and drops out.
    always_ff @(posedge ref_clk) begin
        if (reset || !level) begin
            count_r <= '0;
        end else if (count_r <= limit && count_r != '1) begin
            count_r <= count_r + 1'b1;
        end
    end

    assign qualified = level && (count_r > limit);
endmodule : mdfm_filter

// ==== mdfm_fault_manager.sv ====
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module mdfm_fault_manager
    import mdfm_pkg::*;
#(
    parameter int TIME_WIDTH = 16,
    parameter int RETRY_WIDTH = 32
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Register port.
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Detector inputs.
    input wire mdfm_pkg::mdfm_detect_t detect,
    // Outputs to pin, bridge and reset request.
    output logic fault_pin_low_n,
    output mdfm_pkg::mdfm_bridge_cmd_t bridge_cmd,
    output logic device_reset_req
);
    import mdfm_pkg::*;

    logic [31:0] ctrl_r;
    logic [31:0] mode_r;
    logic [TIME_WIDTH-1:0] oc_time_r;
    logic [TIME_WIDTH-1:0] hl_time_r;
    logic [RETRY_WIDTH-1:0] oc_retry_r;
    logic [RETRY_WIDTH-1:0] hl_retry_r;
    logic [6:0] status_r;
    logic [5:0] fet_flags_r;
    mdfm_state_t oc_state_r;
    mdfm_state_t hl_state_r;
    logic [RETRY_WIDTH-1:0] oc_cnt_r;
    logic [RETRY_WIDTH-1:0] hl_cnt_r;
    logic heat_pin_r;
    logic clear_cmd;
    logic overvoltage_enable;
    logic overvoltage_level_select;
    logic alarm_output_mask;
    logic heat_warning_report_enable;
    mdfm_oc_mode_t overcurrent_response_mode;
    logic [3:0] hard_current_limit_mode;
    logic ov_act;
    logic [5:0] fet_qual;
    logic oc_event;
    logic hl_event;
    logic buck_event;
    logic hl_ignore;

    // Decoded control fields.
    assign overvoltage_enable = ctrl_r[MDFM_CTRL_OV_EN];
    assign overvoltage_level_select = ctrl_r[MDFM_CTRL_OV_SEL];
    assign alarm_output_mask = ctrl_r[MDFM_CTRL_ALARM_MASK];
    assign heat_warning_report_enable = ctrl_r[MDFM_CTRL_HEAT_REP];
    assign overcurrent_response_mode = mdfm_oc_mode_t'(mode_r[MDFM_MODE_OC_LSB +: 2]);
    assign hard_current_limit_mode = mode_r[MDFM_MODE_HL_LSB +: 4];
    assign clear_cmd = reg_write && (reg_addr == MDFM_REG_CMD) && reg_wdata[0];

    // Overvoltage is a live condition gated by the enable; trip level by select.
    assign ov_act = overvoltage_enable &&
        (overvoltage_level_select ? detect.ov_high_trip : detect.ov_low_trip);

    // One filter per FET plus the sense and buck comparators.
    for (genvar i = 0; i < 6; i++) begin : g_fet
        mdfm_filter #(.WIDTH(TIME_WIDTH)) u_fet (
            .ref_clk(ref_clk),
            .reset(reset),
            .level(detect.fet_over[i]),
            .limit(oc_time_r),
            .qualified(fet_qual[i])
        );
    end
    mdfm_filter #(.WIDTH(TIME_WIDTH)) u_sense (
        .ref_clk(ref_clk),
        .reset(reset),
        .level(detect.sense_over),
        .limit(hl_time_r),
        .qualified(hl_event)
    );
    mdfm_filter #(.WIDTH(TIME_WIDTH)) u_buck (
        .ref_clk(ref_clk),
        .reset(reset),
        .level(detect.buck_over),
        .limit(oc_time_r),
        .qualified(buck_event)
    );

    assign oc_event = (|fet_qual) && (overcurrent_response_mode != MDFM_OC_OFF);
    assign hl_ignore = hard_current_limit_mode[3] && hard_current_limit_mode[0];

    // Configuration registers written by software.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl_r <= MDFM_CTRL_RST;
            mode_r <= MDFM_MODE_RST;
            oc_time_r <= TIME_WIDTH'(MDFM_OC_TIME_RST);
            hl_time_r <= TIME_WIDTH'(MDFM_HL_TIME_RST);
            oc_retry_r <= RETRY_WIDTH'(MDFM_RETRY_RST[15:0]);
            hl_retry_r <= RETRY_WIDTH'(MDFM_RETRY_RST[31:16]);
        end else if (reg_write) begin
            case (reg_addr)
                MDFM_REG_CTRL: ctrl_r <= {28'h0000000, reg_wdata[3:0]};
                MDFM_REG_MODE: mode_r <= {24'h000000, reg_wdata[7:0]};
                MDFM_REG_OC_TIME: oc_time_r <= reg_wdata[TIME_WIDTH-1:0];
                MDFM_REG_HL_TIME: hl_time_r <= reg_wdata[TIME_WIDTH-1:0];
                MDFM_REG_RETRY: begin
                    oc_retry_r <= RETRY_WIDTH'(reg_wdata[15:0]);
                    hl_retry_r <= RETRY_WIDTH'(reg_wdata[31:16]);
                end
                default: ;
            endcase
        end
    end

    // Overcurrent handler; the latched state holds until both clear and quiet.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            oc_state_r <= MDFM_ST_IDLE;
            oc_cnt_r <= '0;
        end else begin
            case (oc_state_r)
                MDFM_ST_IDLE: begin
                    oc_cnt_r <= '0;
                    if (oc_event) begin
                        case (overcurrent_response_mode)
                            MDFM_OC_LATCH: oc_state_r <= MDFM_ST_LATCHED;
                            MDFM_OC_RETRY: oc_state_r <= MDFM_ST_RETRYING;
                            default: oc_state_r <= MDFM_ST_REPORTING;
                        endcase
                    end
                end
                MDFM_ST_LATCHED, MDFM_ST_REPORTING: begin
                    if (clear_cmd && !(|fet_qual)) begin
                        oc_state_r <= MDFM_ST_IDLE;
                    end
                end
                MDFM_ST_RETRYING: begin
                    if (oc_cnt_r >= oc_retry_r) begin
                        oc_state_r <= MDFM_ST_IDLE;
                    end else begin
                        oc_cnt_r <= oc_cnt_r + 1'b1;
                    end
                end
                default: oc_state_r <= MDFM_ST_IDLE;
            endcase
        end
    end

    // Hard current-limit handler, same shape with its own retry time.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hl_state_r <= MDFM_ST_IDLE;
            hl_cnt_r <= '0;
        end else begin
            case (hl_state_r)
                MDFM_ST_IDLE: begin
                    hl_cnt_r <= '0;
                    if (hl_event && !hl_ignore) begin
                        if (hard_current_limit_mode[3]) begin
                            hl_state_r <= MDFM_ST_REPORTING;
                        end else if (hard_current_limit_mode[2]) begin
                            hl_state_r <= MDFM_ST_RETRYING;
                        end else begin
                            hl_state_r <= MDFM_ST_LATCHED;
                        end
                    end
                end
                MDFM_ST_LATCHED, MDFM_ST_REPORTING: begin
                    if (clear_cmd && !hl_event) begin
                        hl_state_r <= MDFM_ST_IDLE;
                    end
                end
                MDFM_ST_RETRYING: begin
                    if (hl_cnt_r >= hl_retry_r) begin
                        hl_state_r <= MDFM_ST_IDLE;
                    end else begin
                        hl_cnt_r <= hl_cnt_r + 1'b1;
                    end
                end
                default: hl_state_r <= MDFM_ST_IDLE;
            endcase
        end
    end

    // OV, OC, heat and per-FET flags hold until a clear; the hard-limit pair follows its handler; a new event beats a clear in the same cycle.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            status_r <= '0;
            fet_flags_r <= '0;
        end else begin
            status_r[MDFM_ST_DRIVE_ERR] <= ov_act || oc_event ||
                ((oc_state_r == MDFM_ST_LATCHED || oc_state_r == MDFM_ST_REPORTING) &&
                !(clear_cmd && !(|fet_qual))) ||
                ((oc_state_r == MDFM_ST_RETRYING) && (oc_cnt_r < oc_retry_r)) ||
                (status_r[MDFM_ST_DRIVE_ERR] && !clear_cmd && oc_state_r != MDFM_ST_RETRYING);
            status_r[MDFM_ST_OV] <= ov_act || (status_r[MDFM_ST_OV] && !clear_cmd);
            status_r[MDFM_ST_OC] <= oc_event || (status_r[MDFM_ST_OC] && !clear_cmd);
            status_r[MDFM_ST_CTRL_ERR] <= (hl_event && !hl_ignore) || (hl_state_r != MDFM_ST_IDLE &&
                !(hl_state_r == MDFM_ST_RETRYING && hl_cnt_r >= hl_retry_r));
            status_r[MDFM_ST_HL] <= (hl_event && !hl_ignore) || (hl_state_r != MDFM_ST_IDLE &&
                !(hl_state_r == MDFM_ST_RETRYING && hl_cnt_r >= hl_retry_r));
            status_r[MDFM_ST_OVERTEMP] <= detect.heat_over ||
                (status_r[MDFM_ST_OVERTEMP] && !clear_cmd);
            status_r[MDFM_ST_HEAT] <= detect.heat_over ||
                (status_r[MDFM_ST_HEAT] && !clear_cmd);
            fet_flags_r <= (oc_event ? fet_qual : 6'h00) | (clear_cmd ? 6'h00 : fet_flags_r);
        end
    end

    // Thermal warning pin request holds until the die cools past hysteresis.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            heat_pin_r <= 1'b0;
        end else if (!heat_warning_report_enable) begin
            heat_pin_r <= 1'b0;
        end else if (detect.heat_over) begin
            heat_pin_r <= 1'b1;
        end else if (detect.heat_below_hys) begin
            heat_pin_r <= 1'b0;
        end
    end

    // Fault pin and bridge force are registered so they never glitch.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fault_pin_low_n <= 1'b1;
            bridge_cmd <= '0;
            device_reset_req <= 1'b0;
        end else begin
            fault_pin_low_n <= !(ov_act || heat_pin_r ||
                oc_state_r == MDFM_ST_LATCHED || oc_state_r == MDFM_ST_RETRYING ||
                (oc_state_r == MDFM_ST_REPORTING && !alarm_output_mask) ||
                hl_state_r == MDFM_ST_LATCHED || hl_state_r == MDFM_ST_RETRYING ||
                (hl_state_r == MDFM_ST_REPORTING && !alarm_output_mask));
            device_reset_req <= buck_event;
            if (ov_act || oc_state_r == MDFM_ST_LATCHED || oc_state_r == MDFM_ST_RETRYING) begin
                bridge_cmd <= '{forced: 1'b1, state: MDFM_BR_OFF};
            end else if (hl_state_r == MDFM_ST_LATCHED || hl_state_r == MDFM_ST_RETRYING) begin
                bridge_cmd <= '{forced: 1'b1, state: mdfm_bridge_t'(hard_current_limit_mode[1:0])};
            end else begin
                bridge_cmd <= '0;
            end
        end
    end

    // Read port; unmapped addresses read zero.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            case (reg_addr)
                MDFM_REG_CTRL: reg_rdata <= ctrl_r;
                MDFM_REG_MODE: reg_rdata <= mode_r;
                MDFM_REG_OC_TIME: reg_rdata <= 32'(oc_time_r);
                MDFM_REG_HL_TIME: reg_rdata <= 32'(hl_time_r);
                MDFM_REG_RETRY: reg_rdata <= {hl_retry_r[15:0], oc_retry_r[15:0]};
                MDFM_REG_STATUS: reg_rdata <= {25'h0, status_r};
                MDFM_REG_FET_FLAGS: reg_rdata <= {26'h0, fet_flags_r};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // Latched shutdown keeps the bridge off until clear.
    latch_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
        oc_state_r == MDFM_ST_LATCHED && !clear_cmd |=> bridge_cmd.forced)
        else $error("Latched overcurrent released bridge without clear.");
    ov_off_a: assert property (@(posedge ref_clk) disable iff (reset)
        ov_act |=> !fault_pin_low_n && bridge_cmd.forced && bridge_cmd.state == MDFM_BR_OFF)
        else $error("Overvoltage did not shut down.");
    ov_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
        !overvoltage_enable && !status_r[MDFM_ST_OV] |=> !status_r[MDFM_ST_OV])
        else $error("Overvoltage acted while disabled.");
    oc_off_a: assert property (@(posedge ref_clk) disable iff (reset)
        overcurrent_response_mode == MDFM_OC_OFF && oc_state_r == MDFM_ST_IDLE |=> oc_state_r == MDFM_ST_IDLE)
        else $error("Disabled overcurrent mode acted.");
    hl_ign_a: assert property (@(posedge ref_clk) disable iff (reset)
        hl_ignore && hl_state_r == MDFM_ST_IDLE |=> hl_state_r == MDFM_ST_IDLE)
        else $error("Ignored hard-limit mode acted.");
    ov_sticky_a: assert property (@(posedge ref_clk) disable iff (reset)
        status_r[MDFM_ST_OV] && !clear_cmd |=> status_r[MDFM_ST_OV])
        else $error("Overvoltage flag dropped without clear.");
    buck_rst_a: assert property (@(posedge ref_clk) disable iff (reset)
        buck_event |=> device_reset_req)
        else $error("Buck overcurrent gave no reset request.");
    heat_act_a: assert property (@(posedge ref_clk) disable iff (reset)
        detect.heat_over |=> status_r[MDFM_ST_HEAT] && status_r[MDFM_ST_OVERTEMP])
        else $error("Heat warning flags not set.");
    heat_pin_a: assert property (@(posedge ref_clk) disable iff (reset)
        !heat_warning_report_enable |=> !heat_pin_r)
        else $error("Heat warning drove pin while unreported.");

    // Driving resumes as soon as no source holds the bridge.
    ov_release_a: assert property (@(posedge ref_clk) disable iff (reset)
        !ov_act && oc_state_r == MDFM_ST_IDLE && hl_state_r == MDFM_ST_IDLE |=> !bridge_cmd.forced)
        else $error("Bridge stayed forced with no fault.");

    // Retry expiry returns to idle and drops the drive error.
    oc_retry_a: assert property (@(posedge ref_clk) disable iff (reset)
        oc_state_r == MDFM_ST_RETRYING && oc_cnt_r >= oc_retry_r && !ov_act && !(|fet_qual) |=>
        oc_state_r == MDFM_ST_IDLE && !status_r[MDFM_ST_DRIVE_ERR])
        else $error("Overcurrent retry did not recover.");

    // Overcurrent and per-FET flags outlive recovery until a clear.
    oc_sticky_a: assert property (@(posedge ref_clk) disable iff (reset)
        status_r[MDFM_ST_OC] && !clear_cmd |=> status_r[MDFM_ST_OC])
        else $error("Overcurrent flag dropped without clear.");
    fet_sticky_a: assert property (@(posedge ref_clk) disable iff (reset)
        !clear_cmd |=> (fet_flags_r & $past(fet_flags_r)) == $past(fet_flags_r))
        else $error("Per-FET flag dropped without clear.");

    // A latched overcurrent holds the pin low.
    oc_pin_a: assert property (@(posedge ref_clk) disable iff (reset)
        oc_state_r == MDFM_ST_LATCHED |=> !fault_pin_low_n)
        else $error("Latched overcurrent released the pin.");

    // Report-only faults leave the bridge running; the mask silences the pin.
    oc_report_a: assert property (@(posedge ref_clk) disable iff (reset)
        oc_state_r == MDFM_ST_REPORTING && hl_state_r == MDFM_ST_IDLE && !ov_act |=> !bridge_cmd.forced)
        else $error("Report-only overcurrent forced the bridge.");
    mask_pin_a: assert property (@(posedge ref_clk) disable iff (reset)
        alarm_output_mask && !ov_act && !heat_pin_r && oc_state_r inside {MDFM_ST_IDLE, MDFM_ST_REPORTING} &&
        hl_state_r inside {MDFM_ST_IDLE, MDFM_ST_REPORTING} |=> fault_pin_low_n)
        else $error("Masked report drove the pin.");

    // A latched hard limit applies the chosen bridge state and keeps its flags.
    hl_state_a: assert property (@(posedge ref_clk) disable iff (reset)
        hl_state_r == MDFM_ST_LATCHED && oc_state_r == MDFM_ST_IDLE && !ov_act && !reg_write |=>
        bridge_cmd.forced && bridge_cmd.state == mdfm_bridge_t'(hard_current_limit_mode[1:0]))
        else $error("Latched hard limit gave a wrong bridge state.");
    hl_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
        hl_state_r == MDFM_ST_LATCHED |-> status_r[MDFM_ST_CTRL_ERR] && status_r[MDFM_ST_HL])
        else $error("Latched hard limit lost its flags.");

    // Hard-limit retry expiry resumes and clears both flags.
    hl_retry_a: assert property (@(posedge ref_clk) disable iff (reset)
        hl_state_r == MDFM_ST_RETRYING && hl_cnt_r >= hl_retry_r && !hl_event |=>
        hl_state_r == MDFM_ST_IDLE && !status_r[MDFM_ST_HL] && !status_r[MDFM_ST_CTRL_ERR])
        else $error("Hard-limit retry did not recover.");

    // A clear while the die is still hot leaves the warning standing.
    heat_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
        detect.heat_over && clear_cmd |=> status_r[MDFM_ST_HEAT] && status_r[MDFM_ST_OVERTEMP])
        else $error("Heat warning flag cleared while hot.");
endmodule : mdfm_fault_manager

// ==== mdfm_host_model.sv ====
`timescale 1ns/1ps
// Host controller that watches the fault pin and tallies every fresh alarm.
module mdfm_host_model (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Fault pin from the device.
    input wire logic fault_pin_low_n,
    // Number of alarms seen.
    output logic [7:0] alarm_count
);
    logic pin_r;
    // Count falling edges only, because a report-only fault leaves the motor running
    // and the host must act on each new alarm itself.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin_r <= 1'b1;
            alarm_count <= 8'h00;
        end else begin
            pin_r <= fault_pin_low_n;
            if (pin_r && !fault_pin_low_n) begin
                alarm_count <= alarm_count + 8'h01;
            end
        end
    end
endmodule : mdfm_host_model

// ==== test_motor_driver_fault_manager.sv ====
`timescale 1ns/1ps
module test_motor_driver_fault_manager;
    import mdfm_pkg::*;
    localparam logic [31:0] st_drv = 32'h1 << MDFM_ST_DRIVE_ERR;
    localparam logic [31:0] st_ov = 32'h1 << MDFM_ST_OV;
    localparam logic [31:0] st_oc = 32'h1 << MDFM_ST_OC;
    localparam logic [31:0] st_ctl = 32'h1 << MDFM_ST_CTRL_ERR;
    localparam logic [31:0] st_hl = 32'h1 << MDFM_ST_HL;
    localparam logic [31:0] st_ot = 32'h1 << MDFM_ST_OVERTEMP;
    localparam logic [31:0] st_ht = 32'h1 << MDFM_ST_HEAT;
    logic ref_clk, reset, reg_write, reg_read, fault_pin_low_n, device_reset_req, last_pin, msk, pr, lat, ign;
    logic [3:0] reg_addr, hm;
    logic [31:0] reg_wdata, reg_rdata;
    mdfm_detect_t det, dv, idle;
    mdfm_bridge_cmd_t bridge_cmd;
    logic [7:0] alarm_count;
    int bad_count, checked, cycles, exp_alarms, fi;

    mdfm_fault_manager dut_u (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .detect(det),
        .fault_pin_low_n(fault_pin_low_n), .bridge_cmd(bridge_cmd), .device_reset_req(device_reset_req));
    mdfm_host_model host_u (.ref_clk(ref_clk), .reset(reset), .fault_pin_low_n(fault_pin_low_n),
        .alarm_count(alarm_count));

    // Free-running 250 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Watchdog: the whole run needs about two thousand cycles.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : wt

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
        end
    endtask : chk_reg

    // Compares {fault pin, bridge command}; also tracks how many alarms the host should see.
    task automatic chk_out(input logic [3:0] e);
        checked++;
        if (!e[3] && last_pin) exp_alarms++;
        last_pin = e[3];
        if ({fault_pin_low_n, bridge_cmd} !== e) begin
            bad_count++;
            $display("unexpected at %0t: outputs %h, wanted %h", $time, {fault_pin_low_n, bridge_cmd}, e);
        end
    endtask : chk_out

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1;
        chk_reg(reg_rdata & m, e);
    endtask : rd

    task automatic set_det(input mdfm_detect_t v);
        @(posedge ref_clk);
        det <= v;
    endtask : set_det

    task automatic clr();
        wr(MDFM_REG_CMD, 32'h1);
    endtask : clr

    // Raise a fault, drop it, then clear; outputs and flags are checked at each stage.
    task automatic fault_case(input mdfm_detect_t on, input logic [3:0] o1, input logic [31:0] s1,
        input logic [3:0] o2, input logic [31:0] s2, input logic [31:0] m2, input logic [31:0] f);
        set_det(on);
        wt(10);
        chk_out(o1);
        rd(MDFM_REG_STATUS, s1, '1);
        rd(MDFM_REG_FET_FLAGS, f, '1);
        set_det(idle);
        wt(30);
        chk_out(o2);
        rd(MDFM_REG_STATUS, s2, m2);
        rd(MDFM_REG_FET_FLAGS, f, '1);
        clr();
        wt(3);
        chk_out(4'h8);
        rd(MDFM_REG_STATUS, 32'h0, '1);
        rd(MDFM_REG_FET_FLAGS, 32'h0, '1);
    endtask : fault_case

    // Main sequence.
    initial begin
        reset = 1'b1;
        {reg_write, reg_read, reg_addr, reg_wdata} = '0;
        idle = '0;
        idle.heat_below_hys = 1'b1;
        det = idle;
        last_pin = 1'b1;
        void'($urandom(32'hdb95));
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        rd(MDFM_REG_CTRL, MDFM_CTRL_RST, '1);
        rd(MDFM_REG_MODE, MDFM_MODE_RST, '1);
        rd(MDFM_REG_OC_TIME, 32'(MDFM_OC_TIME_RST), '1);
        rd(MDFM_REG_HL_TIME, 32'(MDFM_HL_TIME_RST), '1);
        rd(MDFM_REG_RETRY, MDFM_RETRY_RST, '1);
        wr(4'hc, $urandom);
        rd(4'hc, 32'h0, '1);
        $display("test reset_values done");
        // A level held for exactly the filter count must not qualify.
        dv = idle;
        dv.fet_over = 6'h01;
        set_det(dv);
        repeat (3) @(posedge ref_clk);
        set_det(idle);
        wt(10);
        chk_out(4'h8);
        rd(MDFM_REG_STATUS, 32'h0, '1);
        $display("test filter_edge done");
        dv = idle;
        dv.ov_low_trip = 1'b1;
        fault_case(dv, 4'h8, 0, 4'h8, 0, '1, 0);
        wr(MDFM_REG_CTRL, 32'h3);
        fault_case(dv, 4'h8, 0, 4'h8, 0, '1, 0);
        dv.ov_high_trip = 1'b1;
        fault_case(dv, 4'h4, st_drv | st_ov, 4'h8, st_ov, ~st_drv, 0);
        wr(MDFM_REG_CTRL, 32'h1);
        dv.ov_high_trip = 1'b0;
        fault_case(dv, 4'h4, st_drv | st_ov, 4'h8, st_ov, ~st_drv, 0);
        $display("test overvoltage done");
        wr(MDFM_REG_RETRY, 32'h0014_0014);
        for (int m = 0; m < 4; m++) begin
            msk = 1'($urandom);
            fi = $urandom_range(5);
            pr = (m == 2) ? msk : 1'b1;
            wr(MDFM_REG_MODE, 32'(m));
            wr(MDFM_REG_CTRL, {29'h0, msk, 2'h0});
            dv = idle;
            dv.fet_over = 6'h01 << fi;
            fault_case(dv, {(m < 2) ? 1'b0 : pr, m < 2, 2'b00}, (m < 3) ? st_drv | st_oc : 0,
                {(m == 0) ? 1'b0 : pr, m == 0, 2'b00}, (m == 1) ? st_oc : ((m < 3) ? st_drv | st_oc : 0),
                '1, (m < 3) ? 32'h1 << fi : 0);
        end
        $display("test overcurrent done");
        for (int m = 0; m < 16; m++) begin
            hm = 4'(m);
            msk = 1'($urandom);
            lat = (hm[3:2] == 2'b00);
            ign = hm[3] & hm[0];
            pr = hm[3] ? (hm[0] | msk) : 1'b0;
            wr(MDFM_REG_MODE, {24'h0, hm, 4'h3});
            wr(MDFM_REG_CTRL, {29'h0, msk, 2'h0});
            dv = idle;
            dv.sense_over = 1'b1;
            fault_case(dv, {pr, !hm[3], hm[3] ? 2'b00 : hm[1:0]}, ign ? 0 : st_ctl | st_hl,
                {lat ? 1'b0 : (!hm[3] | pr), lat, lat ? hm[1:0] : 2'b00},
                (hm[3:2] == 2'b01 || ign) ? 0 : st_ctl | st_hl, '1, 0);
        end
        $display("test hard_limit done");
        wr(MDFM_REG_CTRL, 32'h0);
        dv = idle;
        dv.heat_over = 1'b1;
        dv.heat_below_hys = 1'b0;
        set_det(dv);
        wt(4);
        chk_out(4'h8);
        rd(MDFM_REG_STATUS, st_ot | st_ht, '1);
        wr(MDFM_REG_CTRL, 32'h8);
        wt(3);
        chk_out(4'h0);
        clr();
        wt(3);
        rd(MDFM_REG_STATUS, st_ht, st_ht);
        dv.heat_over = 1'b0;
        set_det(dv);
        wt(3);
        chk_out(4'h0);
        set_det(idle);
        wt(3);
        chk_out(4'h8);
        rd(MDFM_REG_STATUS, st_ht, st_ht);
        clr();
        wt(3);
        rd(MDFM_REG_STATUS, 32'h0, st_ht);
        $display("test heat_warning done");
        chk_reg({24'h0, alarm_count}, 32'(exp_alarms));
        dv = idle;
        dv.buck_over = 1'b1;
        set_det(dv);
        wt(10);
        chk_reg({31'h0, device_reset_req}, 32'h1);
        set_det(idle);
        wt(10);
        chk_reg({31'h0, device_reset_req}, 32'h0);
        $display("test buck_reset done");
        results();
    end
endmodule : test_motor_driver_fault_manager
